// file: hw/dcam_top.sv
/*
 Dual-channel alarm monitor: registers, per-channel evaluation, status and pin.
 Assumes samples arrive with a one-cycle strobe per internal sample cycle, data
 already in each source's 14-bit signed format, and a read strobe for status.
*/
// How it works
// - two independent channels, shared configuration register
// - rate window is sample count times period
// - threshold bit 15 picks greater or less
// - threshold bits 13:0 value, bit 14 unused
// - sample count bits 7:0, upper unused
// - config 15:12 picks channel two source
// - config 11:8 picks channel one source
// - config bit 7 rate mode channel two
// - config bit 6 rate mode channel one
// - config bit 4 filtered versus unfiltered data
// - config bit 2 enables alarm pin
// - config bit 1 sets pin polarity
// - config bit 0 picks general line two
// - all alarm registers reset to zero
// - status bits 9 and 8 show alarms
// - status read clears; persisting alarm resets
`timescale 1ns/1ps
module dcam_top #(
   parameter int DW = 14  // Sample width
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // Register write port
   input  wire dcam_pkg::dcam_wr_t      reg_wr,
   // Sample bus: one strobe per sample cycle
   input  wire logic                    sample_tick,
   input  wire logic [11*DW-1:0]        raw_data,
   input  wire logic [11*DW-1:0]        filt_data,
   // Status read strobe
   input  wire logic                    diag_read,
   // Register readback
   output logic [15:0]                  alarm_threshold_one,
   output logic [15:0]                  alarm_threshold_two,
   output logic [15:0]                  alarm_window_samples_one,
   output logic [15:0]                  alarm_window_samples_two,
   output logic [15:0]                  alarm_configuration,
   // Alarm status bits of the diagnostic flags
   output logic [1:0]                   diagnostic_flags,
   // General-purpose lines
   output logic                         general_io_line_one,
   output logic                         general_io_line_one_oe,
   output logic                         general_io_line_two,
   output logic                         general_io_line_two_oe
);

   // ---------------------------------------------------------------------
   // Local sizes
   // ---------------------------------------------------------------------

   // Number of alarm channels
   localparam int NCH  = 2;
   // Lanes on each sample bus, one per selectable source
   localparam int NL   = dcam_pkg::NUM_SOURCES;
   // History entries kept per channel for the rate window
   localparam int HD   = dcam_pkg::HIST_DEPTH;
   // History index width
   localparam int HW   = $clog2(HD);
   // Width of the monitored value, one bit above the sample for differences
   localparam int MW   = DW + 1;
   // Width of a source selection code
   localparam int SRCW = dcam_pkg::CFG_SRC2_LSB - dcam_pkg::CFG_SRC1_LSB;

   // ---------------------------------------------------------------------
   // Register next values
   // ---------------------------------------------------------------------

   logic [15:0] thr1_d;     // Next threshold, channel one
   logic [15:0] thr2_d;     // Next threshold, channel two
   logic [15:0] win1_d;     // Next sample count, channel one
   logic [15:0] win2_d;     // Next sample count, channel two
   logic [15:0] cfg_d;      // Next shared configuration

   // Decode one write request; unused bits are masked so they read as zero
   always_comb begin
      thr1_d = alarm_threshold_one;
      thr2_d = alarm_threshold_two;
      win1_d = alarm_window_samples_one;
      win2_d = alarm_window_samples_two;
      cfg_d  = alarm_configuration;
      // Only a strobed request changes anything
      if (reg_wr.wr) begin
         unique case (reg_wr.idx)
            // Direction bit 15 and value bits 13:0 kept, bit 14 dropped
            dcam_pkg::REG_THRESH_ONE: begin
               thr1_d = reg_wr.data & dcam_pkg::THR_MASK;
            end
            dcam_pkg::REG_THRESH_TWO: begin
               thr2_d = reg_wr.data & dcam_pkg::THR_MASK;
            end
            // Only the low byte of a sample count is kept
            dcam_pkg::REG_WINDOW_ONE: begin
               win1_d = reg_wr.data & dcam_pkg::WIN_MASK;
            end
            dcam_pkg::REG_WINDOW_TWO: begin
               win2_d = reg_wr.data & dcam_pkg::WIN_MASK;
            end
            // Bits 5 and 3 of the configuration are not kept
            dcam_pkg::REG_CONFIG: begin
               cfg_d = reg_wr.data & dcam_pkg::CFG_MASK;
            end
            // Indices above the configuration register hold nothing
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Register storage; these flops are the readback outputs themselves
   // ---------------------------------------------------------------------

   // All five registers clear to zero, so both channels start disabled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         alarm_threshold_one      <= dcam_pkg::REG_RESET;
         alarm_threshold_two      <= dcam_pkg::REG_RESET;
         alarm_window_samples_one <= dcam_pkg::REG_RESET;
         alarm_window_samples_two <= dcam_pkg::REG_RESET;
         alarm_configuration      <= dcam_pkg::REG_RESET;
      end else begin
         alarm_threshold_one      <= thr1_d;
         alarm_threshold_two      <= thr2_d;
         alarm_window_samples_one <= win1_d;
         alarm_window_samples_two <= win2_d;
         alarm_configuration      <= cfg_d;
      end
   end

   // ---------------------------------------------------------------------
   // Source data
   // ---------------------------------------------------------------------

   // One shared choice between filtered and unfiltered samples
   wire logic [NL*DW-1:0] src_bus;
   assign src_bus = alarm_configuration[dcam_pkg::CFG_FILT_BIT] ? filt_data : raw_data;

   // ---------------------------------------------------------------------
   // Per-channel evaluation
   // ---------------------------------------------------------------------

   wire logic [NCH-1:0] act_d;     // Next live condition per channel
   wire logic [NCH-1:0] flag_d;    // Next sticky status flag per channel
   logic      [NCH-1:0] act_q;     // Live condition per channel

   // Each channel has its own settings, apart from the shared filtered/unfiltered choice, and its own history, and never looks at the other
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      // Field positions of this channel in the shared configuration
      localparam int SRC_LSB = (g == 0) ? dcam_pkg::CFG_SRC1_LSB : dcam_pkg::CFG_SRC2_LSB;
      localparam int ROC_BIT = (g == 0) ? dcam_pkg::CFG_ROC1_BIT : dcam_pkg::CFG_ROC2_BIT;

      wire logic [15:0]        thr_r;    // This channel's threshold register
      wire logic [15:0]        win_r;    // This channel's sample count register
      wire dcam_pkg::dcam_chan_t set_s;  // Settings gathered for evaluation
      logic [DW-1:0]           cur;      // Current sample of the chosen source
      logic [DW-1:0]           hist_q [HD];  // Past samples, oldest overwritten
      logic [HW-1:0]           wptr_q;   // Next history slot to fill
      wire logic [HW-1:0]      span;     // Window length in samples
      wire logic [HW-1:0]      rd_idx;   // Slot holding the sample one window back
      wire logic [DW-1:0]      old;      // Sample one window back
      wire logic               en;       // Channel has a legal source
      wire logic signed [MW-1:0] diff;   // Change over the window
      wire logic signed [MW-1:0] mon;    // Quantity under comparison
      wire logic signed [MW-1:0] thrv;   // Threshold, sign extended
      wire logic               hit;      // Comparison true this cycle

      // Pick this channel's registers
      assign thr_r = (g == 0) ? alarm_threshold_one : alarm_threshold_two;
      assign win_r = (g == 0) ? alarm_window_samples_one : alarm_window_samples_two;

      // Gather the settings that the evaluation needs
      assign set_s = '{src: alarm_configuration[SRC_LSB +: SRCW],
                       roc: alarm_configuration[ROC_BIT],
                       dir: thr_r[dcam_pkg::THR_DIR_BIT],
                       thr: thr_r[dcam_pkg::THR_VAL_MSB:0],
                       cnt: win_r[dcam_pkg::WIN_CNT_MSB:0]};

      // Code zero or a code past the last source leaves the channel idle
      assign en = (set_s.src != dcam_pkg::SRC_OFF) && (set_s.src <= dcam_pkg::SRC_LAST);

      // Source code k+1 reads lane k of the sample bus
      always_comb begin
         cur = '0;
         for (int k = 0; k < NL; k++) begin
            // Lane matches the programmed code
            if (set_s.src == SRCW'(k + 1)) begin
               cur = src_bus[k*DW +: DW];
            end
         end
      end

      // History records the chosen sample once per sample cycle; entries not
      // yet filled read zero, so a fresh rate window may see a false step
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            wptr_q <= '0;
            for (int k = 0; k < HD; k++) begin
               hist_q[k] <= '0;
            end
         end else if (sample_tick) begin
            hist_q[wptr_q] <= cur;
            wptr_q         <= wptr_q + HW'(1);
         end
      end

      // A count of zero acts as a window of one sample
      assign span   = (set_s.cnt == '0) ? HW'(1) : HW'(set_s.cnt);
      // Window in time is the count times the sample period
      assign rd_idx = wptr_q - span;
      assign old    = hist_q[rd_idx];

      // Change since one window ago
      assign diff = MW'($signed(cur)) - MW'($signed(old));
      // Rate mode compares the change, static mode the level
      assign mon  = set_s.roc ? diff : MW'($signed(cur));
      // Threshold in the source's own signed format
      assign thrv = MW'($signed(set_s.thr));
      // Direction bit picks greater than or less than
      assign hit  = set_s.dir ? (mon > thrv) : (mon < thrv);

      // Live condition follows each evaluation and drops when disabled
      assign act_d[g] = !en ? 1'b0 : (sample_tick ? hit : act_q[g]);

      // Status read clears, but a hit in the same cycle wins
      assign flag_d[g] = (sample_tick && en && hit) ? 1'b1 :
                         (diag_read ? 1'b0 : diagnostic_flags[g]);
   end

   // ---------------------------------------------------------------------
   // Live conditions
   // ---------------------------------------------------------------------

   // Held between sample cycles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         act_q <= '0;
      end else begin
         act_q <= act_d;
      end
   end

   // ---------------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------------

   // Bit 0 carries channel one, bit 1 channel two
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         diagnostic_flags <= '0;
      end else begin
         diagnostic_flags <= flag_d;
      end
   end

   // ---------------------------------------------------------------------
   // Alarm pin
   // ---------------------------------------------------------------------

   wire logic any_act;   // Either channel active after this edge
   wire logic pin_lvl;   // Level to drive while the pin is enabled
   wire logic use_one;   // Drive general line one
   wire logic use_two;   // Drive general line two

   // Next values of bits 2:0 are used so pin enable, polarity and line never lag a configuration write
   assign any_act = |act_d;
   assign pin_lvl = ~(any_act ^ cfg_d[dcam_pkg::CFG_POL_BIT]);
   assign use_one = cfg_d[dcam_pkg::CFG_OEN_BIT] && !cfg_d[dcam_pkg::CFG_LINE_BIT];
   assign use_two = cfg_d[dcam_pkg::CFG_OEN_BIT] && cfg_d[dcam_pkg::CFG_LINE_BIT];

   // An undriven line rests low with its enable off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         general_io_line_one    <= 1'b0;
         general_io_line_one_oe <= 1'b0;
         general_io_line_two    <= 1'b0;
         general_io_line_two_oe <= 1'b0;
      end else begin
         general_io_line_one    <= use_one && pin_lvl;
         general_io_line_one_oe <= use_one;
         general_io_line_two    <= use_two && pin_lvl;
         general_io_line_two_oe <= use_two;
      end
   end
endmodule : dcam_top

// file: hw/dcam_pkg.sv
/*
 Shared constants and carrier types for the dual-channel alarm monitor.
 Assumes the register write port and sensor sample bus of the enclosing device.
*/
package dcam_pkg;
   // Register indices on the internal register port
   localparam logic [2:0] REG_THRESH_ONE  = 3'h0;
   localparam logic [2:0] REG_THRESH_TWO  = 3'h1;
   localparam logic [2:0] REG_WINDOW_ONE  = 3'h2;
   localparam logic [2:0] REG_WINDOW_TWO  = 3'h3;
   localparam logic [2:0] REG_CONFIG      = 3'h4;
   // Reset value shared by every alarm register
   localparam logic [15:0] REG_RESET      = 16'h0000;
   // Threshold fields
   localparam int THR_DIR_BIT   = 15;
   localparam int THR_VAL_MSB   = 13;
   // Sample count field
   localparam int WIN_CNT_MSB   = 7;
   // Configuration fields
   localparam int CFG_SRC2_LSB  = 12;
   localparam int CFG_SRC1_LSB  = 8;
   localparam int CFG_ROC2_BIT  = 7;
   localparam int CFG_ROC1_BIT  = 6;
   localparam int CFG_FILT_BIT  = 4;
   localparam int CFG_OEN_BIT   = 2;
   localparam int CFG_POL_BIT   = 1;
   localparam int CFG_LINE_BIT  = 0;
   // Write masks: unused bits read as zero
   localparam logic [15:0] THR_MASK = 16'hBFFF;
   localparam logic [15:0] WIN_MASK = 16'h00FF;
   localparam logic [15:0] CFG_MASK = 16'hFFD7;
   // Source codes
   localparam logic [3:0] SRC_OFF     = 4'h0;
   localparam logic [3:0] SRC_LAST    = 4'hB;
   localparam int         NUM_SOURCES = 11;
   // Status bit positions
   localparam int STAT_ALM1_BIT = 8;
   localparam int STAT_ALM2_BIT = 9;
   // Depth of the rate-of-change history (8-bit sample count)
   localparam int HIST_DEPTH    = 256;

   // Register write request
   typedef struct packed {
      logic        wr;
      logic [2:0]  idx;
      logic [15:0] data;
   } dcam_wr_t;

   // Per-channel settings
   typedef struct packed {
      logic [3:0]  src;
      logic        roc;
      logic        dir;
      logic [13:0] thr;
      logic [7:0]  cnt;
   } dcam_chan_t;
endpackage : dcam_pkg

// file: sim/dcam_asserts.sv
/* Alarm monitor checker; sees the top ports only, bound from the bench. */
`timescale 1ns/1ps
module dcam_asserts(input wire logic mclk, input wire logic rst,
   input wire dcam_pkg::dcam_wr_t reg_wr, input wire logic [15:0] alarm_threshold_one,
   input wire logic [15:0] alarm_window_samples_one, input wire logic [15:0] alarm_configuration,
   input wire logic general_io_line_one_oe, input wire logic general_io_line_two_oe);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_thr_spare: assert property (!alarm_threshold_one[14]) else $error("thr spare");
   a_win_spare: assert property (alarm_window_samples_one[15:8] == 8'h00)
      else $error("win spare");
   a_cfg_write: assert property (reg_wr.wr && reg_wr.idx == 3'h4 |=>
      alarm_configuration == ($past(reg_wr.data) & 16'hFFD7)) else $error("cfg write");
   a_pin_off: assert property (!alarm_configuration[2] |->
      !general_io_line_one_oe && !general_io_line_two_oe) else $error("pin off");
   a_line_sel: assert property (alarm_configuration[2] && alarm_configuration[0] |->
      !general_io_line_one_oe) else $error("line sel");
   a_line_one: assert property (alarm_configuration[2] && !alarm_configuration[0] |->
      general_io_line_one_oe && !general_io_line_two_oe) else $error("line one");
endmodule : dcam_asserts

// file: sim/dcam_host.sv
/* Host model: register writes at the falling edge. Assumes one-cycle write strobe. */
`timescale 1ns/1ps
module dcam_host(input wire logic mclk, output dcam_pkg::dcam_wr_t reg_wr);
   initial reg_wr = '0;
   // Write one register, strobe held one cycle
   task automatic put(input logic [2:0] idx, input logic [15:0] d);
      @(negedge mclk) reg_wr = '{1'b1, idx, d};
      @(negedge mclk) reg_wr.wr = 1'b0;
   endtask : put
endmodule : dcam_host

// file: sim/dcam_top_tb.sv
/* Bench for the alarm monitor. Assumes source code 1 reads lane 0 of the sample bus. */
`timescale 1ns/1ps
module dcam_top_tb;
   logic mclk = 0, rst = 1, sample_tick = 0, diag_read = 0;
   logic [153:0] raw_data = '0, filt_data = '0;
   logic [15:0] alarm_threshold_one, alarm_threshold_two, alarm_window_samples_one;
   logic [15:0] alarm_window_samples_two, alarm_configuration;
   logic [1:0] diagnostic_flags;
   logic general_io_line_one, general_io_line_one_oe, general_io_line_two, general_io_line_two_oe;
   dcam_pkg::dcam_wr_t reg_wr;
   int error_cnt = 0, comparisons = 0, i;
   always #2 mclk = ~mclk;
   always @(negedge mclk) sample_tick <= ~sample_tick;
   dcam_host dcam_host_inst(.*);
   dcam_top dcam_top_inst(.*);
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin error_cnt++; $display("mismatch %0t %h vs %h", $time, s, e); end
   endtask : chk
   task automatic wait_flag(input int b);
      int n;
      for (n = 0; n < 40 && diagnostic_flags[b] !== 1'b1; n++) @(negedge mclk);
      if (n == 40) begin error_cnt++; close_out(); end
   endtask : wait_flag
   task automatic read_stat;
      @(negedge mclk) diag_read = 1'b1;
      @(negedge mclk) diag_read = 1'b0;
   endtask : read_stat
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      repeat (16) @(negedge mclk);
      rst = 0;
      chk(alarm_configuration, 16'h0000);
      chk(alarm_threshold_two, 16'h0000);
      dcam_host_inst.put(3'h0, 16'hFFFF);
      chk(alarm_threshold_one, 16'hBFFF);
      dcam_host_inst.put(3'h3, 16'hFFFF);
      chk(alarm_window_samples_two, 16'h00FF);
      raw_data[13:0] = 14'h0064;
      dcam_host_inst.put(3'h0, 16'h800A);
      dcam_host_inst.put(3'h4, 16'h0106);
      for (i = 0; i < 40 && diagnostic_flags[0] !== 1'b1; i++) @(negedge mclk);
      if (i == 40) begin error_cnt++; close_out(); end
      chk({14'h0, general_io_line_one_oe, general_io_line_one}, 16'h0003);
      dcam_host_inst.put(3'h4, 16'h0000);
      chk({14'h0, general_io_line_one_oe, general_io_line_two_oe}, 16'h0000);
      chk({14'h0, diagnostic_flags}, 16'h0001);
      read_stat();
      chk({14'h0, diagnostic_flags}, 16'h0000);
      raw_data[13:0] = 14'h3F00;
      dcam_host_inst.put(3'h1, 16'h0000);
      dcam_host_inst.put(3'h4, 16'h1005);
      wait_flag(1);
      chk({14'h0, general_io_line_two_oe, general_io_line_two}, 16'h0002);
      dcam_host_inst.put(3'h4, 16'h0146);
      repeat (10) @(negedge mclk);
      read_stat();
      repeat (10) @(negedge mclk);
      chk({14'h0, diagnostic_flags}, 16'h0000);
      raw_data[13:0] = 14'h0064;
      wait_flag(0);
      chk({15'h0, diagnostic_flags[0]}, 16'h0001);
      close_out();
   end
endmodule : dcam_top_tb
bind dcam_top dcam_asserts dcam_asserts_inst(.*);
